//--- ird_cfg.svh
// Constants of the infrared remote frame decoder: register offsets, field
// positions, reset values and timing figures.
// Assumes inclusion by bare name from every file that needs them.
//
// Functional notes
// - Polarity bit 7 swaps the mark/space order of both data symbols.
// - Encoding bit clear decodes biphase halves, set decodes space widths.
// - Header bit clear expects header mark and space before data bits.
// - Address-offset count of data bits is skipped before address bits.
// - Command-offset count of data bits is skipped before command bits.
// - Speed bit picks an 8us or 128us base unit for all widths.
// - Report bit clear flashes LED on address and command, set on address.
// - Header mark nominal is register value times 16 base units.
// - Header space nominal is register value times 16 base units.
// - Data mark nominal is register value times base unit.
// - Logic 0 data space nominal is its register value times base unit.
// - Logic 1 data space nominal is its register value times base unit.
// - Word-order bit clear: address then command; set: command first.
// - Command field length is the 3-bit size value plus one.
// - Address field length is the 4-bit size value plus one.
// - Received address is compared with high and low expected bytes.
// - Expected address bits above the address length are ignored.
// - Matching address with any of eight command codes pulses power-on.
// - Widths pass within margin; margin scaled by 16 units for header.
`ifndef IRD_CFG_SVH
`define IRD_CFG_SVH

`define IRD_OFS_FORMAT 8'h4E
`define IRD_OFS_SPEED 8'h4F
`define IRD_OFS_HDR_MARK 8'h50
`define IRD_OFS_HDR_SPACE 8'h51
`define IRD_OFS_DATA_MARK 8'h52
`define IRD_OFS_SPACE_ZERO 8'h53
`define IRD_OFS_SPACE_ONE 8'h54
`define IRD_OFS_SIZES 8'h55
`define IRD_OFS_ADDR_HIGH 8'h56
`define IRD_OFS_ADDR_LOW 8'h57
`define IRD_OFS_CMD_BASE 5'h0B
`define IRD_OFS_MARGIN 8'h60

`define IRD_POL_BIT 7
`define IRD_MODE_BIT 6
`define IRD_HDR_BIT 5
`define IRD_SKIP_MSB 4
`define IRD_REPORT_BIT 6
`define IRD_SPEED_BIT 5
`define IRD_ORDER_BIT 7
`define IRD_CSIZE_MSB 6
`define IRD_CSIZE_LSB 4
`define IRD_ASIZE_MSB 3

`define IRD_RST_BYTE 8'h00
`define IRD_RST_MARGIN 4'hF
`define IRD_SPEED_RW_MASK 8'h7F

`define IRD_CLK_MHZ 250
`define IRD_UNIT_FAST_US 8
`define IRD_UNIT_SLOW_US 128
`define IRD_HDR_SHIFT 4
`define IRD_IDLE_UNITS 13'h0200

`endif

//--- ird_decoder.sv
// Infrared remote frame decoder: configuration registers, frame sequencer,
// symbol decoding, field capture and address/command matching.
// Assumes a demodulated receiver line (high = mark) from a pin and a simple
// byte register port driven on ref_clk_in.
`timescale 1ns/1ps
`include "ird_cfg.svh"

module ird_decoder #(
  parameter int unsigned FAST_UNIT_CYC = `IRD_UNIT_FAST_US * `IRD_CLK_MHZ,
  parameter int unsigned SLOW_UNIT_CYC = `IRD_UNIT_SLOW_US * `IRD_CLK_MHZ
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic ir_mark_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_en_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic power_on_pulse_out,
  output logic led_flash_out
);

  // Configuration registers
  logic [7:0] ir_frame_format;
  logic [7:0] base_time_unit_select_report_cmd_offset;
  logic [7:0] header_absent_flag_mark_len;
  logic [7:0] header_absent_flag_space_len;
  logic [7:0] ir_data_mark_len;
  logic [7:0] ir_space_len_zero;
  logic [7:0] ir_space_len_one;
  logic [7:0] ir_field_order_sizes;
  logic [7:0] ir_expected_addr_high;
  logic [7:0] ir_expected_addr_low;
  logic [3:0] width_tolerance;
  logic [7:0] cmd_code [0:7];

  // Receiver and sequencer state
  logic ir_meta;
  logic ir_sync;
  ird_pkg::ird_state_t state;
  ird_pkg::ird_state_t next_state;
  logic at_mid;
  logic [6:0] bit_cnt;
  logic [15:0] addr_rx;
  logic [7:0] cmd_rx;
  logic seg_end;
  logic seg_lvl;
  logic [12:0] seg_len;
  logic [12:0] cur_len;
  logic [7:0] cmd_hit;

  function automatic logic in_tol(input logic [12:0] len,
                                  input logic [12:0] nom,
                                  input logic [12:0] mg);
    logic [13:0] len_hi;
    logic [13:0] nom_hi;
    len_hi = {1'b0, len} + {1'b0, mg};
    nom_hi = {1'b0, nom} + {1'b0, mg};
    in_tol = (len_hi >= {1'b0, nom}) && ({1'b0, len} <= nom_hi);
  endfunction : in_tol

  // Register decode
  wire wr_format = reg_wr_en_in && reg_addr_in == `IRD_OFS_FORMAT;
  wire wr_speed = reg_wr_en_in && reg_addr_in == `IRD_OFS_SPEED;
  wire wr_hmark = reg_wr_en_in && reg_addr_in == `IRD_OFS_HDR_MARK;
  wire wr_hspace = reg_wr_en_in && reg_addr_in == `IRD_OFS_HDR_SPACE;
  wire wr_dmark = reg_wr_en_in && reg_addr_in == `IRD_OFS_DATA_MARK;
  wire wr_zero = reg_wr_en_in && reg_addr_in == `IRD_OFS_SPACE_ZERO;
  wire wr_one = reg_wr_en_in && reg_addr_in == `IRD_OFS_SPACE_ONE;
  wire wr_sizes = reg_wr_en_in && reg_addr_in == `IRD_OFS_SIZES;
  wire wr_ahigh = reg_wr_en_in && reg_addr_in == `IRD_OFS_ADDR_HIGH;
  wire wr_alow = reg_wr_en_in && reg_addr_in == `IRD_OFS_ADDR_LOW;
  wire wr_margin = reg_wr_en_in && reg_addr_in == `IRD_OFS_MARGIN;
  wire cmd_sel = reg_addr_in[7:3] == `IRD_OFS_CMD_BASE;

  wire [7:0] rd_mux =
    (reg_addr_in == `IRD_OFS_FORMAT) ? ir_frame_format :
    (reg_addr_in == `IRD_OFS_SPEED) ? base_time_unit_select_report_cmd_offset :
    (reg_addr_in == `IRD_OFS_HDR_MARK) ? header_absent_flag_mark_len :
    (reg_addr_in == `IRD_OFS_HDR_SPACE) ? header_absent_flag_space_len :
    (reg_addr_in == `IRD_OFS_DATA_MARK) ? ir_data_mark_len :
    (reg_addr_in == `IRD_OFS_SPACE_ZERO) ? ir_space_len_zero :
    (reg_addr_in == `IRD_OFS_SPACE_ONE) ? ir_space_len_one :
    (reg_addr_in == `IRD_OFS_SIZES) ? ir_field_order_sizes :
    (reg_addr_in == `IRD_OFS_ADDR_HIGH) ? ir_expected_addr_high :
    (reg_addr_in == `IRD_OFS_ADDR_LOW) ? ir_expected_addr_low :
    (reg_addr_in == `IRD_OFS_MARGIN) ? {4'h0, width_tolerance} :
    cmd_sel ? cmd_code[reg_addr_in[2:0]] : 8'h00;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ir_frame_format <= `IRD_RST_BYTE;
      base_time_unit_select_report_cmd_offset <= `IRD_RST_BYTE;
      header_absent_flag_mark_len <= `IRD_RST_BYTE;
      header_absent_flag_space_len <= `IRD_RST_BYTE;
      ir_data_mark_len <= `IRD_RST_BYTE;
      ir_space_len_zero <= `IRD_RST_BYTE;
      ir_space_len_one <= `IRD_RST_BYTE;
      ir_field_order_sizes <= `IRD_RST_BYTE;
      ir_expected_addr_high <= `IRD_RST_BYTE;
      ir_expected_addr_low <= `IRD_RST_BYTE;
      width_tolerance <= `IRD_RST_MARGIN;
      reg_rdata_out <= 8'h00;
    end else begin
      if (wr_format) ir_frame_format <= reg_wdata_in;
      if (wr_speed) begin
        base_time_unit_select_report_cmd_offset <= reg_wdata_in & `IRD_SPEED_RW_MASK;
      end
      if (wr_hmark) header_absent_flag_mark_len <= reg_wdata_in;
      if (wr_hspace) header_absent_flag_space_len <= reg_wdata_in;
      if (wr_dmark) ir_data_mark_len <= reg_wdata_in;
      if (wr_zero) ir_space_len_zero <= reg_wdata_in;
      if (wr_one) ir_space_len_one <= reg_wdata_in;
      if (wr_sizes) ir_field_order_sizes <= reg_wdata_in;
      if (wr_ahigh) ir_expected_addr_high <= reg_wdata_in;
      if (wr_alow) ir_expected_addr_low <= reg_wdata_in;
      if (wr_margin) width_tolerance <= reg_wdata_in[3:0];
      if (reg_rd_en_in) reg_rdata_out <= rd_mux;
    end
  end

  // Field views
  wire pol = ir_frame_format[`IRD_POL_BIT];
  wire space_mode = ir_frame_format[`IRD_MODE_BIT];
  wire hdr_expected = !ir_frame_format[`IRD_HDR_BIT];
  wire [4:0] addr_skip = ir_frame_format[`IRD_SKIP_MSB:0];
  wire [4:0] cmd_skip = base_time_unit_select_report_cmd_offset[`IRD_SKIP_MSB:0];
  wire addr_only = base_time_unit_select_report_cmd_offset[`IRD_REPORT_BIT];
  wire slow_unit = base_time_unit_select_report_cmd_offset[`IRD_SPEED_BIT];
  wire cmd_first = ir_field_order_sizes[`IRD_ORDER_BIT];
  wire [2:0] cmd_size =
    ir_field_order_sizes[`IRD_CSIZE_MSB:`IRD_CSIZE_LSB];
  wire [3:0] addr_size = ir_field_order_sizes[`IRD_ASIZE_MSB:0];

  wire [14:0] unit_cyc = slow_unit ? 15'(SLOW_UNIT_CYC) :
                                     15'(FAST_UNIT_CYC);

  // Receiver line synchroniser
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ir_meta <= 1'b0;
      ir_sync <= 1'b0;
    end else begin
      ir_meta <= ir_mark_in;
      ir_sync <= ir_meta;
    end
  end

  ird_seg_timer u_seg_timer (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .level_in(ir_sync),
    .unit_cyc_in(unit_cyc),
    .seg_end_out(seg_end),
    .seg_lvl_out(seg_lvl),
    .seg_len_out(seg_len),
    .cur_len_out(cur_len)
  );

  // Nominal widths and margins in base units
  wire [12:0] hm_nom = 13'(header_absent_flag_mark_len) << `IRD_HDR_SHIFT;
  wire [12:0] hs_nom = 13'(header_absent_flag_space_len) << `IRD_HDR_SHIFT;
  wire [12:0] mk_nom = 13'(ir_data_mark_len);
  wire [12:0] mk2_nom = 13'(ir_data_mark_len) << 1;
  wire [12:0] z_nom = 13'(ir_space_len_zero);
  wire [12:0] o_nom = 13'(ir_space_len_one);
  wire [12:0] mg_hdr = 13'(width_tolerance) << `IRD_HDR_SHIFT;
  wire [12:0] mg_dat = 13'(width_tolerance);

  wire hm_ok = in_tol(seg_len, hm_nom, mg_hdr);
  wire hs_ok = in_tol(seg_len, hs_nom, mg_hdr);
  wire t_ok = in_tol(seg_len, mk_nom, mg_dat);
  wire t2_ok = in_tol(seg_len, mk2_nom, mg_dat);
  wire z_ok = in_tol(seg_len, z_nom, mg_dat);
  wire o_ok = in_tol(seg_len, o_nom, mg_dat);

  // Biphase: half-bit runs toggle the mid-bit phase, double runs keep it;
  // the level of a run that ends at mid-bit is that bit's first half.
  // Space widths are not consulted here, so software need not keep them
  // equal to the mark width; the decoder ignores them in this encoding.
  wire ph_emit = t_ok ? !at_mid : (t2_ok && at_mid);
  wire ph_err = !t_ok && !(t2_ok && at_mid);
  wire ph_bit = seg_lvl ^ pol;
  wire next_at_mid = t_ok ? !at_mid : at_mid;

  // Space encoding: fixed-level run checked against the mark width, the
  // other level's run carries the bit in its width.
  wire fixed_run = seg_lvl == !pol;
  wire sp_emit = !fixed_run && (z_ok || o_ok);
  wire sp_err = fixed_run ? !t_ok : !(z_ok || o_ok);
  wire sp_bit = !z_ok;

  wire in_data = state == ird_pkg::IRD_ST_DATA;
  wire sym_err = space_mode ? sp_err : ph_err;
  wire data_emit = in_data && seg_end && !sym_err &&
                   (space_mode ? sp_emit : ph_emit);
  wire rx_bit = space_mode ? sp_bit : ph_bit;

  // Field placement
  wire [4:0] addr_len = {1'b0, addr_size} + 5'h01;
  wire [4:0] cmd_len = {2'b00, cmd_size} + 5'h01;
  wire [4:0] f_skip = cmd_first ? cmd_skip : addr_skip;
  wire [4:0] f_len = cmd_first ? cmd_len : addr_len;
  wire [4:0] s_skip = cmd_first ? addr_skip : cmd_skip;
  wire [4:0] s_len = cmd_first ? addr_len : cmd_len;
  wire [6:0] first_end = {2'b00, f_skip} + {2'b00, f_len};
  wire [6:0] s_start = first_end + {2'b00, s_skip};
  wire [6:0] total_bits = s_start + {2'b00, s_len};
  wire [6:0] addr_start = cmd_first ? s_start : {2'b00, f_skip};
  wire [6:0] cmd_start = cmd_first ? {2'b00, f_skip} : s_start;
  wire [6:0] addr_end = addr_start + {2'b00, addr_len};
  wire [6:0] cmd_end = cmd_start + {2'b00, cmd_len};
  wire in_addr = bit_cnt >= addr_start && bit_cnt < addr_end;
  wire in_cmd = bit_cnt >= cmd_start && bit_cnt < cmd_end;
  wire [6:0] addr_idx = bit_cnt - addr_start;
  wire [6:0] cmd_idx = bit_cnt - cmd_start;
  wire last_bit = data_emit && bit_cnt == (total_bits - 7'h01);

  // Matching
  wire [15:0] addr_expect = {ir_expected_addr_high,
                             ir_expected_addr_low};
  wire [15:0] addr_mask = 16'hFFFF >> (4'hF - addr_size);
  wire [7:0] cmd_mask = 8'hFF >> (3'h7 - cmd_size);
  wire addr_ok = ((addr_rx ^ addr_expect) & addr_mask) == 16'h0000;
  wire cmd_ok = |cmd_hit;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_cmd
      wire wr_this = reg_wr_en_in && cmd_sel && reg_addr_in[2:0] == gi;
      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          cmd_code[gi] <= `IRD_RST_BYTE;
        end else if (wr_this) begin
          cmd_code[gi] <= reg_wdata_in;
        end
      end
      assign cmd_hit[gi] = ((cmd_rx ^ cmd_code[gi]) & cmd_mask) == 8'h00;
    end
  endgenerate

  // Frame sequencer
  wire quiet = !ir_sync && cur_len >= `IRD_IDLE_UNITS;
  wire cur_sat = cur_len == 13'h1FFF;
  wire frame_start = state == ird_pkg::IRD_ST_ARMED && seg_end;

  always_comb begin
    next_state = state;
    case (state)
      ird_pkg::IRD_ST_QUIET: begin
        if (quiet) next_state = ird_pkg::IRD_ST_ARMED;
      end
      ird_pkg::IRD_ST_ARMED: begin
        if (seg_end) begin
          next_state = hdr_expected ? ird_pkg::IRD_ST_HDR_MARK
                                    : ird_pkg::IRD_ST_DATA;
        end
      end
      ird_pkg::IRD_ST_HDR_MARK: begin
        if (seg_end) begin
          next_state = hm_ok ? ird_pkg::IRD_ST_HDR_SPACE
                             : ird_pkg::IRD_ST_QUIET;
        end else if (cur_sat) begin
          next_state = ird_pkg::IRD_ST_QUIET;
        end
      end
      ird_pkg::IRD_ST_HDR_SPACE: begin
        if (seg_end) begin
          next_state = hs_ok ? ird_pkg::IRD_ST_DATA
                             : ird_pkg::IRD_ST_QUIET;
        end else if (cur_sat) begin
          next_state = ird_pkg::IRD_ST_QUIET;
        end
      end
      ird_pkg::IRD_ST_DATA: begin
        if (seg_end && sym_err) begin
          next_state = ird_pkg::IRD_ST_QUIET;
        end else if (last_bit) begin
          next_state = ird_pkg::IRD_ST_EVAL;
        end else if (cur_len >= `IRD_IDLE_UNITS) begin
          next_state = ird_pkg::IRD_ST_QUIET;
        end
      end
      ird_pkg::IRD_ST_EVAL: begin
        next_state = ird_pkg::IRD_ST_QUIET;
      end
      default: begin
        next_state = ird_pkg::IRD_ST_QUIET;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state <= ird_pkg::IRD_ST_QUIET;
    end else begin
      state <= next_state;
    end
  end

  // Bit capture, LSB of each field first
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      at_mid <= 1'b0;
      bit_cnt <= 7'h00;
      addr_rx <= 16'h0000;
      cmd_rx <= 8'h00;
    end else if (frame_start) begin
      at_mid <= 1'b0;
      bit_cnt <= 7'h00;
      addr_rx <= 16'h0000;
      cmd_rx <= 8'h00;
    end else begin
      if (in_data && seg_end && !space_mode) at_mid <= next_at_mid;
      if (data_emit) begin
        bit_cnt <= bit_cnt + 7'h01;
        if (in_addr) addr_rx[addr_idx[3:0]] <= rx_bit;
        if (in_cmd) cmd_rx[cmd_idx[2:0]] <= rx_bit;
      end
    end
  end

  // Match reporting
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      power_on_pulse_out <= 1'b0;
      led_flash_out <= 1'b0;
    end else begin
      power_on_pulse_out <= state == ird_pkg::IRD_ST_EVAL &&
                            addr_ok && cmd_ok;
      led_flash_out <= state == ird_pkg::IRD_ST_EVAL && addr_ok &&
                       (addr_only || cmd_ok);
    end
  end

endmodule : ird_decoder

//--- ird_decoder_checker.sv
// Port checker for the infrared frame decoder, bound to ird_decoder.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "ird_cfg.svh"

module ird_decoder_checker (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic ir_mark_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_en_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic power_on_pulse_out,
  input wire logic led_flash_out
);
  logic prev_mark;
  logic [3:0] edge_age;
  wire logic mark_edge = ir_mark_in != prev_mark;
  wire logic unmapped = reg_addr_in < `IRD_OFS_FORMAT ||
                        reg_addr_in > `IRD_OFS_MARGIN;

  // Cycles since the line last changed, saturating
  always_ff @(posedge ref_clk_in) begin
    prev_mark <= ir_mark_in;
    if (sys_rst_in || edge_age == 4'hF) begin
      edge_age <= mark_edge ? 4'h0 : 4'hF;
    end else begin
      edge_age <= mark_edge ? 4'h0 : edge_age + 4'h1;
    end
  end

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_reset_clears: assert property ($fell(sys_rst_in) |->
    reg_rdata_out == 8'h00 && !power_on_pulse_out && !led_flash_out)
    else $error("outputs not cleared by reset");
  a_power_single: assert property (
    power_on_pulse_out |=> !power_on_pulse_out)
    else $error("power-on pulse longer than one cycle");
  a_led_single: assert property (led_flash_out |=> !led_flash_out)
    else $error("led pulse longer than one cycle");
  a_power_needs_led: assert property (
    power_on_pulse_out |-> led_flash_out)
    else $error("power-on pulse without led pulse");
  a_pulse_after_edge: assert property (
    led_flash_out |-> edge_age inside {[2:10]})
    else $error("match pulse not tied to a line edge");
  a_unmapped_zero: assert property (
    reg_rd_en_in && unmapped |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_margin_upper: assert property (
    reg_rd_en_in && reg_addr_in == `IRD_OFS_MARGIN |=>
    reg_rdata_out[7:4] == 4'h0)
    else $error("margin upper bits not zero");
  a_speed_reserved: assert property (
    reg_rd_en_in && reg_addr_in == `IRD_OFS_SPEED |=> !reg_rdata_out[7])
    else $error("speed register bit 7 not zero");
  a_rdata_holds: assert property (
    !reg_rd_en_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  a_mark_len_rw: assert property (
    reg_wr_en_in && reg_addr_in == `IRD_OFS_DATA_MARK ##1
    reg_rd_en_in && !reg_wr_en_in && reg_addr_in == `IRD_OFS_DATA_MARK
    |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("data mark width not read back");
endmodule : ird_decoder_checker

bind ird_decoder ird_decoder_checker chk_u (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .ir_mark_in(ir_mark_in), .reg_addr_in(reg_addr_in),
  .reg_wr_en_in(reg_wr_en_in), .reg_rd_en_in(reg_rd_en_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .power_on_pulse_out(power_on_pulse_out), .led_flash_out(led_flash_out));

//--- ird_decoder_tb_top.sv
// Self-checking bench for the infrared frame decoder with a remote model.
// Assumes short base units of 4 and 8 cycles in the design.
`timescale 1ns/1ps
`include "ird_cfg.svh"

module ird_decoder_tb_top;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_en_in = 1'b0;
  logic reg_rd_en_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  wire logic ir_mark;
  wire logic [7:0] reg_rdata_out;
  wire logic power_on_pulse_out;
  wire logic led_flash_out;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int pwr_n = 0;
  int led_n = 0;

  initial forever #2 ref_clk_in = ~ref_clk_in;

  ird_decoder #(.FAST_UNIT_CYC(4), .SLOW_UNIT_CYC(8)) dut_u (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .ir_mark_in(ir_mark),
    .reg_addr_in(reg_addr_in), .reg_wr_en_in(reg_wr_en_in),
    .reg_rd_en_in(reg_rd_en_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .power_on_pulse_out(power_on_pulse_out),
    .led_flash_out(led_flash_out));

  ird_remote_model #(.FAST_CYC(4), .SLOW_CYC(8)) remote_u (
    .ref_clk_in(ref_clk_in), .ir_mark_out(ir_mark));

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge ref_clk_in) begin
    cycles++;
    if (power_on_pulse_out === 1'b1) pwr_n++;
    if (led_flash_out === 1'b1) led_n++;
    if (cycles == 60000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_en_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    reg_wr_en_in = 1'b0;
  endtask : wr

  task rd_chk(input string name, input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    #1;
    reg_addr_in = a;
    reg_rd_en_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    reg_rd_en_in = 1'b0;
    chk(name, reg_rdata_out, e);
  endtask : rd_chk

  task cfg(input logic [7:0] fmt, input logic [7:0] spd, input logic [7:0] sz);
    wr(`IRD_OFS_FORMAT, fmt);
    wr(`IRD_OFS_SPEED, spd);
    wr(`IRD_OFS_SIZES, sz);
  endtask : cfg

  task frame(input string name, input logic [31:0] bits, input int n,
             input logic [7:0] ep, input logic [7:0] el);
    pwr_n = 0;
    led_n = 0;
    remote_u.send(bits, n);
    repeat (8) @(posedge ref_clk_in);
    chk({name, " power"}, pwr_n[7:0], ep);
    chk({name, " led"}, led_n[7:0], el);
  endtask : frame

  task t_regs;
    logic [7:0] e;
    for (int a = 'h4D; a <= 'h61; a++) begin
      chk("idle pulses", {6'h00, power_on_pulse_out, led_flash_out}, 8'h00);
      rd_chk("reset value", a[7:0], a == 'h60 ? 8'h0F : 8'h00);
      wr(a[7:0], 8'hFF);
    end
    for (int a = 'h4D; a <= 'h61; a++) begin
      e = (a == 'h4D || a == 'h61) ? 8'h00 : a == 'h4F ? 8'h7F :
          a == 'h60 ? 8'h0F : 8'hFF;
      rd_chk("register", a[7:0], e);
    end
    @(posedge ref_clk_in);
    #1;
    reg_addr_in = `IRD_OFS_DATA_MARK;
    reg_wdata_in = 8'h5A;
    reg_wr_en_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    reg_wr_en_in = 1'b0;
    reg_rd_en_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    reg_rd_en_in = 1'b0;
    chk("mark back to back", reg_rdata_out, 8'h5A);
  endtask : t_regs

  task t_space;
    wr(`IRD_OFS_DATA_MARK, 8'h04);
    wr(`IRD_OFS_SPACE_ZERO, 8'h04);
    wr(`IRD_OFS_SPACE_ONE, 8'h0C);
    wr(`IRD_OFS_MARGIN, 8'h01);
    wr(`IRD_OFS_ADDR_HIGH, 8'hFF);
    wr(`IRD_OFS_ADDR_LOW, 8'hA5);
    for (int i = 0; i < 8; i++) wr(8'h58 + i[7:0], i == 7 ? 8'h06 : 8'h01);
    cfg(8'h60, 8'h00, 8'h23);
    frame("space match", 32'h65, 7, 8'h01, 8'h01);
    frame("wrong command", 32'h25, 7, 8'h00, 8'h00);
    wr(`IRD_OFS_SPEED, 8'h40);
    frame("address only", 32'h25, 7, 8'h00, 8'h01);
    frame("wrong address", 32'h64, 7, 8'h00, 8'h00);
  endtask : t_space

  task t_order;
    cfg(8'h62, 8'h01, 8'hA3);
    frame("offset order", 32'h15D, 10, 8'h01, 8'h01);
  endtask : t_order

  task t_header_slow;
    cfg(8'h40, 8'h20, 8'h23);
    wr(`IRD_OFS_HDR_MARK, 8'h02);
    wr(`IRD_OFS_HDR_SPACE, 8'h01);
    remote_u.hdr_on = 1'b1;
    remote_u.slow = 1'b1;
    remote_u.hm = 2;
    frame("header slow", 32'h65, 7, 8'h01, 8'h01);
    remote_u.hm = 4;
    frame("long header", 32'h65, 7, 8'h00, 8'h00);
    remote_u.hdr_on = 1'b0;
    remote_u.slow = 1'b0;
  endtask : t_header_slow

  task t_phase;
    wr(`IRD_OFS_SPACE_ONE, 8'h04);
    cfg(8'h20, 8'h00, 8'h23);
    remote_u.phase = 1'b1;
    frame("phase normal", 32'h65, 7, 8'h01, 8'h01);
    cfg(8'hA1, 8'h00, 8'h23);
    remote_u.pol = 1'b1;
    frame("phase inverted", 32'hCA, 8, 8'h01, 8'h01);
    remote_u.pol = 1'b0;
    remote_u.phase = 1'b0;
    wr(`IRD_OFS_SPACE_ONE, 8'h0C);
  endtask : t_phase

  task t_tolerance;
    cfg(8'h60, 8'h00, 8'h23);
    remote_u.mk = 8;
    frame("mark too long", 32'h65, 7, 8'h00, 8'h00);
    remote_u.mk = 5;
    frame("mark in margin", 32'h65, 7, 8'h01, 8'h01);
    remote_u.mk = 4;
    cfg(8'hE0, 8'h00, 8'h23);
    remote_u.pol = 1'b1;
    frame("space inverted", 32'h65, 7, 8'h01, 8'h01);
    remote_u.pol = 1'b0;
  endtask : t_tolerance

  initial begin
    repeat (10) @(posedge ref_clk_in);
    #1;
    sys_rst_in = 1'b0;
    t_regs();
    t_space();
    t_order();
    t_header_slow();
    t_phase();
    t_tolerance();
    report_and_stop();
  end
endmodule : ird_decoder_tb_top

//--- ird_pkg.sv
// Types shared by the infrared remote frame decoder.
// Assumes nothing of its surroundings.
package ird_pkg;

  typedef enum logic [5:0] {
    IRD_ST_QUIET = 6'h01,
    IRD_ST_ARMED = 6'h02,
    IRD_ST_HDR_MARK = 6'h04,
    IRD_ST_HDR_SPACE = 6'h08,
    IRD_ST_DATA = 6'h10,
    IRD_ST_EVAL = 6'h20
  } ird_state_t;

endpackage : ird_pkg

//--- ird_remote_model.sv
// Handheld remote model: sends frames on the demodulated receiver line.
// Assumes the bench sets the shape fields before calling send.
`timescale 1ns/1ps

module ird_remote_model #(
  parameter int FAST_CYC = 4,
  parameter int SLOW_CYC = 8
) (
  input wire logic ref_clk_in,
  output logic ir_mark_out
);
  logic pol = 1'b0;
  logic phase = 1'b0;
  logic hdr_on = 1'b0;
  logic slow = 1'b0;
  int hm = 1;
  int hs = 1;
  int mk = 4;
  int zr = 4;
  int on = 12;
  int unit = FAST_CYC;

  initial ir_mark_out = 1'b0;

  task automatic run(input logic lv, input int n);
    ir_mark_out = lv;
    repeat (n * unit) @(posedge ref_clk_in);
    #1;
  endtask : run

  task automatic send(input logic [31:0] bits, input int n);
    unit = slow ? SLOW_CYC : FAST_CYC;
    @(posedge ref_clk_in);
    #1;
    run(1'b0, 520);
    if (hdr_on) begin
      run(1'b1, hm * 16);
      run(1'b0, hs * 16);
    end
    for (int i = 0; i < n; i++) begin
      if (phase) begin
        run(bits[i] ^ pol, mk);
        run(!(bits[i] ^ pol), mk);
      end else begin
        run(!pol, mk);
        run(pol, bits[i] ? on : zr);
      end
    end
    // Close the last symbol with an edge, then rest as space
    if (!ir_mark_out) run(1'b1, mk);
    run(1'b0, 4);
  endtask : send
endmodule : ird_remote_model

//--- ird_seg_timer.sv
// Segment timer: measures each constant-level run of the receiver line in
// base time units and reports it when the level changes.
// Assumes level_in is already synchronised to ref_clk_in.
`timescale 1ns/1ps

module ird_seg_timer (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic level_in,
  input wire logic [14:0] unit_cyc_in,
  output logic seg_end_out,
  output logic seg_lvl_out,
  output logic [12:0] seg_len_out,
  output logic [12:0] cur_len_out
);

  logic prev_lvl;
  logic [14:0] presc;
  logic [12:0] run_len;
  wire edge_seen = level_in != prev_lvl;
  wire unit_done = presc >= (unit_cyc_in - 15'h0001);
  wire run_sat = run_len == 13'h1FFF;
  wire [14:0] next_presc = (edge_seen || unit_done) ? 15'h0000
                                                    : presc + 15'h0001;
  // A unit that completes on the edge cycle still belongs to the run
  wire [12:0] run_end_len = (unit_done && !run_sat) ? run_len + 13'h0001
                                                    : run_len;
  wire [12:0] next_run_len = edge_seen ? 13'h0000 : run_end_len;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      prev_lvl <= 1'b0;
      presc <= 15'h0000;
      run_len <= 13'h0000;
      seg_end_out <= 1'b0;
      seg_lvl_out <= 1'b0;
      seg_len_out <= 13'h0000;
    end else begin
      prev_lvl <= level_in;
      presc <= next_presc;
      run_len <= next_run_len;
      seg_end_out <= edge_seen;
      if (edge_seen) begin
        seg_lvl_out <= prev_lvl;
        seg_len_out <= run_end_len;
      end
    end
  end

  assign cur_len_out = run_len;

endmodule : ird_seg_timer
